// [hw/pmtp_table_pointer.sv]
// Table pointer and data latch moving bytes from program flash and into the write holding registers
`timescale 1ns/1ps
`default_nettype none

module pmtp_table_pointer (
    input wire logic clk,
    input wire logic rst_n,
    input wire pmtp_pkg::pmtp_sfr_t sfrReq,
    output logic [7:0] sfrRdData,
    input wire pmtp_pkg::pmtp_req_t tblReq,
    output logic tblBusy,
    output logic tblDone,
    output logic memRdReq,
    output logic [21:0] memAddr,
    input wire logic memRdValid,
    input wire logic [7:0] memRdData,
    output logic holdWrEn,
    output logic [6:0] holdAddr,
    output logic [7:0] holdData,
    input wire logic writeStart,
    input wire logic eraseStart,
    output logic flashWriteGo,
    output logic flashEraseGo,
    output logic [11:0] blockAddr
);
    import pmtp_pkg::*;

    logic [7:0] latch_reg, latch_next;
    logic [21:0] ptr_reg, ptr_next;
    pmtp_state_t state_reg, state_next;
    logic [7:0] rdData_reg, rdData_next;
    logic busy_reg, busy_next;
    logic done_reg, done_next;
    logic memRdReq_reg, memRdReq_next;
    logic [21:0] memAddr_reg, memAddr_next;
    logic holdWrEn_reg, holdWrEn_next;
    logic [6:0] holdAddr_reg, holdAddr_next;
    logic [7:0] holdData_reg, holdData_next;
    logic writeGo_reg, writeGo_next;
    logic eraseGo_reg, eraseGo_next;
    logic [11:0] block_reg, block_next;

    logic accept;
    logic [21:0] ptrInc, ptrDec, accessAddr;

    always_comb begin
        // Only the 21 address bits count, the space select bit is carried across unchanged
        ptrInc = {ptr_reg[PMTP_PTR_W-1], ptr_reg[PMTP_ADDR_W-1:0] + PMTP_ONE};
        ptrDec = {ptr_reg[PMTP_PTR_W-1], ptr_reg[PMTP_ADDR_W-1:0] - PMTP_ONE};
        accept = tblReq.valid && (state_reg == PMTP_ST_IDLE);
        accessAddr = (tblReq.mode == PMTP_MODE_PREINC) ? ptrInc : ptr_reg;

        latch_next = latch_reg;
        ptr_next = ptr_reg;
        state_next = state_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        memRdReq_next = 1'b0;
        memAddr_next = memAddr_reg;
        holdWrEn_next = 1'b0;
        holdAddr_next = holdAddr_reg;
        holdData_next = holdData_reg;
        writeGo_next = 1'b0;
        eraseGo_next = 1'b0;
        block_next = block_reg;

        // Register writes from the core; a table operation taken in the same cycle wins
        if (sfrReq.write && !accept) begin
            case (sfrReq.sel)
                PMTP_SEL_LATCH: latch_next = sfrReq.data;
                PMTP_SEL_LOW: ptr_next[7:0] = sfrReq.data;
                PMTP_SEL_HIGH: ptr_next[15:8] = sfrReq.data;
                PMTP_SEL_UPPER: ptr_next[21:16] = sfrReq.data[5:0];
                default: ptr_next = ptr_reg;
            endcase
        end

        case (state_reg)
            PMTP_ST_IDLE: begin
                if (accept) begin
                    case (tblReq.mode)
                        PMTP_MODE_NONE: ptr_next = ptr_reg;
                        PMTP_MODE_POSTINC: ptr_next = ptrInc;
                        PMTP_MODE_POSTDEC: ptr_next = ptrDec;
                        PMTP_MODE_PREINC: ptr_next = ptrInc;
                        default: ptr_next = ptr_reg;
                    endcase
                    if (tblReq.write) begin
                        holdWrEn_next = 1'b1;
                        holdAddr_next = accessAddr[PMTP_HOLD_LSB +: PMTP_HOLD_W];
                        holdData_next = latch_reg;
                        state_next = PMTP_ST_DONE;
                    end else begin
                        // Full pointer goes out, bit 21 picks the ID/config space
                        memRdReq_next = 1'b1;
                        memAddr_next = accessAddr;
                        state_next = PMTP_ST_READ;
                    end
                    busy_next = 1'b1;
                end
            end
            PMTP_ST_READ: begin
                // The flash answer has no time limit here; the core stalls on busy
                if (memRdValid) begin
                    latch_next = memRdData;
                    state_next = PMTP_ST_DONE;
                end
            end
            PMTP_ST_DONE: begin
                done_next = 1'b1;
                busy_next = 1'b0;
                state_next = PMTP_ST_IDLE;
            end
            default: begin
                state_next = PMTP_ST_IDLE;
                busy_next = 1'b0;
            end
        endcase

        // Block selection ignores the low ten pointer bits
        if (writeStart || eraseStart) begin
            block_next = ptr_reg[PMTP_BLOCK_LSB +: PMTP_BLOCK_W];
            writeGo_next = writeStart;
            eraseGo_next = eraseStart && !writeStart;
        end

        case (sfrReq.sel)
            PMTP_SEL_LATCH: rdData_next = latch_reg;
            PMTP_SEL_LOW: rdData_next = ptr_reg[7:0];
            PMTP_SEL_HIGH: rdData_next = ptr_reg[15:8];
            PMTP_SEL_UPPER: rdData_next = {2'h0, ptr_reg[21:16]};
            default: rdData_next = 8'h00;
        endcase
        if (!sfrReq.read) begin
            rdData_next = rdData_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_reg <= PMTP_LATCH_RST;
            ptr_reg <= PMTP_PTR_RST;
            state_reg <= PMTP_ST_IDLE;
            rdData_reg <= 8'h00;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            memRdReq_reg <= 1'b0;
            memAddr_reg <= PMTP_PTR_RST;
            holdWrEn_reg <= 1'b0;
            holdAddr_reg <= 7'h00;
            holdData_reg <= 8'h00;
            writeGo_reg <= 1'b0;
            eraseGo_reg <= 1'b0;
            block_reg <= 12'h000;
        end else begin
            latch_reg <= latch_next;
            ptr_reg <= ptr_next;
            state_reg <= state_next;
            rdData_reg <= rdData_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            memRdReq_reg <= memRdReq_next;
            memAddr_reg <= memAddr_next;
            holdWrEn_reg <= holdWrEn_next;
            holdAddr_reg <= holdAddr_next;
            holdData_reg <= holdData_next;
            writeGo_reg <= writeGo_next;
            eraseGo_reg <= eraseGo_next;
            block_reg <= block_next;
        end
    end

    assign sfrRdData = rdData_reg;
    assign tblBusy = busy_reg;
    assign tblDone = done_reg;
    assign memRdReq = memRdReq_reg;
    assign memAddr = memAddr_reg;
    assign holdWrEn = holdWrEn_reg;
    assign holdAddr = holdAddr_reg;
    assign holdData = holdData_reg;
    assign flashWriteGo = writeGo_reg;
    assign flashEraseGo = eraseGo_reg;
    assign blockAddr = block_reg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence seqTake(pmtp_mode_t m);
        accept && tblReq.mode == m;
    endsequence

    // Steps of a table transfer as the core sees them on the outputs
    sequence seqHoldPulse;
        holdWrEn && tblBusy && !tblDone;
    endsequence
    sequence seqAskFlash;
        memRdReq && tblBusy && !tblDone;
    endsequence
    sequence seqFinish;
        tblDone && !tblBusy && !holdWrEn && !memRdReq;
    endsequence

    chk_latch_readback: assert property (
        sfrReq.read && sfrReq.sel == PMTP_SEL_LATCH |=> sfrRdData == $past(latch_reg))
        else $error("latch read back wrong");
    chk_upper_zero: assert property (
        sfrReq.read && sfrReq.sel == PMTP_SEL_UPPER |=> sfrRdData[7:6] == 2'h0
            && sfrRdData[5:0] == $past(ptr_reg[21:16]))
        else $error("upper byte read back wrong");
    chk_plain_hold: assert property (
        seqTake(PMTP_MODE_NONE) |=> ptr_reg == $past(ptr_reg))
        else $error("plain access moved pointer");
    chk_postinc_step: assert property (
        seqTake(PMTP_MODE_POSTINC) |=> ptr_reg[20:0] == $past(ptr_reg[20:0]) + 21'h1)
        else $error("post-increment wrong");
    chk_postdec_step: assert property (
        seqTake(PMTP_MODE_POSTDEC) |=> ptr_reg[20:0] == $past(ptr_reg[20:0]) - 21'h1)
        else $error("post-decrement wrong");
    chk_preinc_addr: assert property (
        accept && tblReq.mode == PMTP_MODE_PREINC && !tblReq.write
            |=> memRdReq && memAddr == ptr_reg && ptr_reg[20:0] == $past(ptr_reg[20:0]) + 21'h1)
        else $error("pre-increment address wrong");
    chk_top_bit: assert property (
        accept |=> ptr_reg[21] == $past(ptr_reg[21]))
        else $error("auto step touched top bit");
    chk_read_latch: assert property (
        state_reg == PMTP_ST_READ && memRdValid |=> latch_reg == $past(memRdData) ##1 tblDone && !tblBusy)
        else $error("read byte not latched");
    chk_hold_write: assert property (
        accept && tblReq.write && tblReq.mode != PMTP_MODE_PREINC
            |=> holdWrEn && holdAddr == $past(ptr_reg[6:0]) && holdData == $past(latch_reg))
        else $error("holding write wrong");
    chk_block_sel: assert property (
        writeStart || eraseStart |=> blockAddr == $past(ptr_reg[21:10]) && (flashWriteGo || flashEraseGo))
        else $error("block select wrong");

    // Register port writes; a table operation taken in the same cycle drops them
    chk_low_write: assert property (
        sfrReq.write && !accept && sfrReq.sel == PMTP_SEL_LOW |=> ptr_reg[7:0] == $past(sfrReq.data))
        else $error("low byte write lost");
    chk_high_write: assert property (
        sfrReq.write && !accept && sfrReq.sel == PMTP_SEL_HIGH |=> ptr_reg[15:8] == $past(sfrReq.data))
        else $error("high byte write lost");
    chk_upper_write: assert property (
        sfrReq.write && !accept && sfrReq.sel == PMTP_SEL_UPPER |=> ptr_reg[21:16] == $past(sfrReq.data[5:0]))
        else $error("upper byte write lost");
    chk_latch_write: assert property (
        sfrReq.write && !accept && sfrReq.sel == PMTP_SEL_LATCH && !(state_reg == PMTP_ST_READ && memRdValid)
            |=> latch_reg == $past(sfrReq.data))
        else $error("latch write lost");
    chk_write_lost: assert property (
        sfrReq.write && accept |=> latch_reg == $past(latch_reg))
        else $error("register write taken during table accept");

    // Transfer steps and one-cycle pulses
    chk_write_steps: assert property (
        accept && tblReq.write |=> seqHoldPulse ##1 seqFinish)
        else $error("table write steps wrong");
    chk_read_request: assert property (
        accept && !tblReq.write |=> seqAskFlash
            ##0 memAddr == ($past(tblReq.mode) == PMTP_MODE_PREINC ? ptr_reg : $past(ptr_reg)))
        else $error("flash request wrong");
    chk_space_select: assert property (
        accept && !tblReq.write |=> memAddr[21] == $past(ptr_reg[21]))
        else $error("space select bit lost");
    chk_preinc_write: assert property (
        accept && tblReq.write && tblReq.mode == PMTP_MODE_PREINC |=> holdAddr == $past(ptr_reg[6:0]) + 7'h1)
        else $error("pre-increment holding slot wrong");
    chk_busy_refuse: assert property (
        tblBusy |-> !accept)
        else $error("request taken while busy");
    chk_done_pulse: assert property (
        tblDone |=> !tblDone)
        else $error("done longer than one cycle");
    chk_read_pulse: assert property (
        memRdReq |=> !memRdReq)
        else $error("flash request longer than one cycle");
    chk_hold_pulse: assert property (
        holdWrEn |=> !holdWrEn)
        else $error("holding write longer than one cycle");

    // Timed write and erase starts
    chk_write_wins: assert property (
        writeStart |=> flashWriteGo && !flashEraseGo)
        else $error("write start lost");
    chk_erase_only: assert property (
        eraseStart && !writeStart |=> flashEraseGo && !flashWriteGo)
        else $error("erase start lost");
    chk_go_idle: assert property (
        !writeStart && !eraseStart |=> !flashWriteGo && !flashEraseGo && $stable(blockAddr))
        else $error("start pulse without request");
endmodule

`default_nettype wire

// [hw/pmtp_pkg.sv]
// Package for the program memory table pointer block: widths, selects, modes, states
package pmtp_pkg;
    localparam int PMTP_PTR_W = 22;
    localparam int PMTP_ADDR_W = 21;
    localparam int PMTP_DATA_W = 8;
    localparam int PMTP_HOLD_W = 7;
    localparam int PMTP_HOLD_LSB = 0;
    localparam int PMTP_BLOCK_W = 12;
    localparam int PMTP_BLOCK_LSB = 10;
    localparam int PMTP_SEL_W = 2;
    localparam logic [1:0] PMTP_SEL_LATCH = 2'h0;
    localparam logic [1:0] PMTP_SEL_LOW = 2'h1;
    localparam logic [1:0] PMTP_SEL_HIGH = 2'h2;
    localparam logic [1:0] PMTP_SEL_UPPER = 2'h3;
    localparam logic [7:0] PMTP_LATCH_RST = 8'h00;
    localparam logic [21:0] PMTP_PTR_RST = 22'h000000;
    localparam logic [20:0] PMTP_ONE = 21'h000001;

    typedef enum logic [1:0] {
        PMTP_MODE_NONE = 2'b00,
        PMTP_MODE_POSTINC = 2'b01,
        PMTP_MODE_POSTDEC = 2'b10,
        PMTP_MODE_PREINC = 2'b11
    } pmtp_mode_t;

    typedef enum logic [1:0] {
        PMTP_ST_IDLE = 2'b00,
        PMTP_ST_READ = 2'b01,
        PMTP_ST_DONE = 2'b10
    } pmtp_state_t;

    typedef struct packed {
        logic valid;
        logic write;
        pmtp_mode_t mode;
    } pmtp_req_t;

    typedef struct packed {
        logic write;
        logic read;
        logic [1:0] sel;
        logic [7:0] data;
    } pmtp_sfr_t;
endpackage

// [verification/pmtp_flash_model.sv]
// Flash read port model answering byte fetches after a chosen wait
`timescale 1ns/1ps
`default_nettype none
module pmtp_flash_model (
    input wire logic clk,
    input wire logic memRdReq,
    input wire logic [21:0] memAddr,
    input wire logic [2:0] waitCycles,
    output logic memRdValid,
    output logic [7:0] memRdData
);
    logic [21:0] addr = 22'h000000;
    logic validQ = 1'b0;
    logic [7:0] dataQ = 8'h00;
    int cnt = -1;
    always @(posedge clk) begin
        validQ <= (cnt == 0) && !memRdReq;
        // Data lines toggle outside the answer cycle so a stale sample is caught
        dataQ <= (cnt == 0) ? addr[7:0] ^ addr[15:8] ^ {addr[21:16], 2'h1} : ~dataQ;
        if (memRdReq) begin
            addr <= memAddr;
            cnt <= int'(waitCycles);
        end else if (cnt >= 0) begin
            cnt <= cnt - 1;
        end
    end
    assign memRdValid = validQ;
    assign memRdData = dataQ;
endmodule
`default_nettype wire

// [verification/program_memory_table_pointer_tb.sv]
// Self-checking bench for the program memory table pointer
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin testsRun++; if ((g) !== (e)) begin $display("CHECK FAILED %s exp %h got %h", n, e, g); miscompares++; end end
module program_memory_table_pointer_tb;
    import pmtp_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    pmtp_sfr_t sfrReq = '0;
    pmtp_req_t tblReq = '0;
    logic writeStart = 1'b0;
    logic eraseStart = 1'b0;
    logic [2:0] waitCycles = 3'h0;
    logic [7:0] sfrRdData, memRdData, holdData;
    logic tblBusy, tblDone, memRdReq, memRdValid, holdWrEn, flashWriteGo, flashEraseGo;
    logic [21:0] memAddr, acc;
    logic [21:0] ptr = 22'h000000;
    logic [6:0] holdAddr;
    logic [11:0] blockAddr;
    logic [7:0] latch = 8'h00;
    logic [31:0] seed = 32'h0000003a;
    int miscompares = 0;
    int testsRun = 0;
    int cycles = 0;
    always #4 clk = ~clk;
    pmtp_table_pointer dut (.clk(clk), .rst_n(rst_n), .sfrReq(sfrReq), .sfrRdData(sfrRdData), .tblReq(tblReq),
        .tblBusy(tblBusy), .tblDone(tblDone), .memRdReq(memRdReq), .memAddr(memAddr), .memRdValid(memRdValid),
        .memRdData(memRdData), .holdWrEn(holdWrEn), .holdAddr(holdAddr), .holdData(holdData),
        .writeStart(writeStart), .eraseStart(eraseStart), .flashWriteGo(flashWriteGo),
        .flashEraseGo(flashEraseGo), .blockAddr(blockAddr));
    pmtp_flash_model flash (.clk(clk), .memRdReq(memRdReq), .memAddr(memAddr), .waitCycles(waitCycles),
        .memRdValid(memRdValid), .memRdData(memRdData));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Only the low 21 bits move; bit 21 rides along unchanged
    function automatic logic [21:0] step(input logic [21:0] p, input logic up);
        return {p[21], up ? p[20:0] + 21'h000001 : p[20:0] - 21'h000001};
    endfunction
    task automatic conclude();
        if (miscompares == 0 && testsRun > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic sfrOp(input logic wr, input logic [1:0] sel, input logic [7:0] d);
        @(posedge clk) sfrReq <= {wr, !wr, sel, d};
        @(posedge clk) sfrReq <= '0;
        #1;
    endtask
    task automatic setPtr(input logic [21:0] p, input logic [1:0] top);
        sfrOp(1'b1, PMTP_SEL_LOW, p[7:0]);
        sfrOp(1'b1, PMTP_SEL_HIGH, p[15:8]);
        sfrOp(1'b1, PMTP_SEL_UPPER, {top, p[21:16]});
        ptr = p;
    endtask
    task automatic checkRegs();
        logic [23:0] exp;
        exp = {2'h0, ptr};
        for (int s = 1; s < 4; s++) begin
            sfrOp(1'b0, 2'(s), 8'h00);
            `CHK("pointer byte", exp[8*(s-1) +: 8], sfrRdData)
        end
        sfrOp(1'b0, PMTP_SEL_LATCH, 8'h00);
        `CHK("latch", latch, sfrRdData)
    endtask
    task automatic tblOp(input logic wr, input pmtp_mode_t m);
        bit done;
        int sawRd, sawHold;
        acc = (m == PMTP_MODE_PREINC) ? step(ptr, 1'b1) : ptr;
        @(posedge clk) tblReq <= {1'b1, wr, m};
        @(posedge clk) tblReq <= '0;
        done = 0;
        sawRd = 0;
        sawHold = 0;
        for (int i = 0; i < 40 && !done; i++) begin
            #1;
            if (memRdReq === 1'b1) begin
                sawRd++;
                `CHK("read address", acc, memAddr)
            end
            if (holdWrEn === 1'b1) begin
                sawHold++;
                `CHK("hold slot", {acc[6:0], latch}, {holdAddr, holdData})
            end
            if (tblDone === 1'b1) begin
                done = 1;
                `CHK("busy at done", 1'b0, tblBusy)
            end else begin
                `CHK("busy", 1'b1, tblBusy)
                @(posedge clk);
            end
        end
        `CHK("done seen", 1'b1, done)
        `CHK("request pulses", {int'(!wr), int'(wr)}, {sawRd, sawHold})
        if (!wr) latch = acc[7:0] ^ acc[15:8] ^ {acc[21:16], 2'h1};
        ptr = (m == PMTP_MODE_NONE) ? ptr : step(ptr, m != PMTP_MODE_POSTDEC);
        checkRegs();
    endtask
    task automatic startOp(input logic w, input logic e);
        @(posedge clk) begin
            writeStart <= w;
            eraseStart <= e;
        end
        @(posedge clk) begin
            writeStart <= 1'b0;
            eraseStart <= 1'b0;
        end
        #1;
        `CHK("go pulses", {w, e & !w, ptr[21:10]}, {flashWriteGo, flashEraseGo, blockAddr})
        @(posedge clk);
        #1;
        `CHK("go drop", 2'b00, {flashWriteGo, flashEraseGo})
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end
    initial begin
        logic [21:0] cp [4];
        cp = '{22'h1fffff, 22'h200000, 22'h3fffff, 22'h0000ff};
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        // Wrap at the top of 21 bits with and without bit 21, at the bottom with bit 21 set, and a byte carry
        for (int i = 0; i < 4; i++) begin
            setPtr(cp[i], 2'h3);
            tblOp(i[0], pmtp_mode_t'(2'(i % 3 + 1)));
        end
        for (int i = 0; i < 28; i++) begin
            seed = lfsr(seed);
            @(posedge clk) waitCycles <= seed[31:29];
            if (seed[28]) setPtr(seed[21:0], seed[31:30]);
            tblOp(seed[27], pmtp_mode_t'(seed[26:25]));
            if (seed[24]) begin
                sfrOp(1'b1, PMTP_SEL_LATCH, seed[7:0]);
                latch = seed[7:0];
            end
            // With neither start the block address holds, so one of them is always asked for
            if (i % 4 == 0) startOp(seed[23], seed[22] | !seed[23]);
        end
        // Mid-run reset: outputs clear at once, registers come back at zero
        @(posedge clk) rst_n <= 1'b0;
        #1;
        `CHK("reset pulses", 6'h00, {tblBusy, tblDone, memRdReq, holdWrEn, flashWriteGo, flashEraseGo})
        `CHK("reset words", 57'h0, {sfrRdData, memAddr, holdAddr, holdData, blockAddr})
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        ptr = 22'h000000;
        latch = 8'h00;
        checkRegs();
        tblOp(1'b0, PMTP_MODE_POSTDEC);
        startOp(1'b1, 1'b1);
        startOp(1'b0, 1'b1);
        conclude();
    end
endmodule
`default_nettype wire
